// ===== logic/lemc_defs.svh
// Timing and field constants for the latched EEPROM host controller
`ifndef LEMC_DEFS_SVH
`define LEMC_DEFS_SVH
`define LEMC_CLK_PERIOD_NS   4
`define LEMC_ADDR_W          11
`define LEMC_DATA_W          8
`define LEMC_ERASE_DATA      8'hFF
// Setup of address, select and drive before strobe fall (ns)
`define LEMC_SETUP_NS        50
`define LEMC_SETUP_CYC       ((`LEMC_SETUP_NS + `LEMC_CLK_PERIOD_NS - 1) / `LEMC_CLK_PERIOD_NS)
// Hold of inputs after strobe fall (ns)
`define LEMC_HOLD_NS         50
`define LEMC_HOLD_CYC        ((`LEMC_HOLD_NS + `LEMC_CLK_PERIOD_NS - 1) / `LEMC_CLK_PERIOD_NS)
// Strobe low width: standard 9 ms, fast variant 1 ms
`define LEMC_WRITE_STD_MS    9
`define LEMC_WRITE_FAST_MS   1
`define LEMC_CYC_PER_MS      (1000000 / `LEMC_CLK_PERIOD_NS)
// Recovery after strobe trailing edge (ns)
`define LEMC_RECOVERY_NS     50
`define LEMC_RECOVERY_CYC    ((`LEMC_RECOVERY_NS + `LEMC_CLK_PERIOD_NS - 1) / `LEMC_CLK_PERIOD_NS)
// Read access time, fastest grade (ns)
`define LEMC_ACCESS_NS       200
`define LEMC_ACCESS_CYC      ((`LEMC_ACCESS_NS + `LEMC_CLK_PERIOD_NS - 1) / `LEMC_CLK_PERIOD_NS)
`define LEMC_CNT_W           24
`endif

// ===== logic/lemc_pkg.sv
// Types for the latched EEPROM host controller
package lemc_pkg;
  typedef enum logic [2:0] {
    LEMC_OP_READ       = 3'h0,
    LEMC_OP_BYTE_ERASE = 3'h1,
    LEMC_OP_BYTE_WRITE = 3'h2,
    LEMC_OP_CHIP_ERASE = 3'h3,
    LEMC_OP_STANDBY    = 3'h4
  } lemc_op_e;

  typedef enum logic [5:0] {
    LEMC_ST_IDLE    = 6'h01,
    LEMC_ST_SETUP   = 6'h02,
    LEMC_ST_STROBE  = 6'h04,
    LEMC_ST_RECOVER = 6'h08,
    LEMC_ST_ACCESS  = 6'h10,
    LEMC_ST_DONE    = 6'h20
  } lemc_state_e;
endpackage : lemc_pkg

// ===== logic/lemc_timer.sv
// Down counter that flags when a loaded cycle count has run out
`include "lemc_defs.svh"
module lemc_timer
  import lemc_pkg::*;
(
  input  wire logic                   ref_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   load,
  input  wire logic [`LEMC_CNT_W-1:0] count,
  output logic                        expired
);
  logic [`LEMC_CNT_W-1:0] cnt_reg;

  assign expired = (cnt_reg == '0);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (!expired) begin
      cnt_reg <= cnt_reg - `LEMC_CNT_W'(1);
    end
  end
endmodule : lemc_timer

// ===== logic/lemc_host.sv
// Host controller driving the pins of a latched 2048 x 8 EEPROM
`include "lemc_defs.svh"
// Functional notes
// R1: Host erases a byte before writing; erase is never implied by write.
// R2: Byte erase: select low, drive high, all data lines driven to ones.
// R3: Device latches address, data, controls on strobe falling edge.
// R4: Device finishes byte erase in under ten milliseconds.
// R5: Byte write uses erase sequence but drives true data.
// R6: Operation lasts up to 9 ms standard, 1 ms fast; parameterised.
// R7: Standard device accepts logic low or high voltage strobe.
// R8: Only strobe falling edge matters; rising edge has no requirement.
// R9: Read: strobe high, select and drive low, device outputs byte.
// R10: Select high gives standby; data lines float, no operation starts.
// R11: Chip erase raises drive pin to high voltage; standard variant only.
// R12: Chip erase clears all 2K bytes within ten milliseconds.
// R13: Erasing or writing one byte leaves others unchanged.
// R14: Read data valid after access time, 200 ns fastest grade.
// R15: Array is 2048 by 8, 11-bit word address.
// R16: Host may release inputs once latched.
// R17: Inputs ignored until recovery time after strobe trailing edge.
// R18: Erase or write blocked unless select and drive at write levels.
// R19: At power ramp, device needs a fresh strobe falling edge.
// R20: Host waits full operation time before next mode.
module lemc_host
  import lemc_pkg::*;
#(
  parameter int WRITE_MS    = `LEMC_WRITE_STD_MS,
  parameter int WRITE_CYC   = WRITE_MS * `LEMC_CYC_PER_MS,
  parameter bit FAST_DEVICE = 1'b0
)
(
  input  wire logic                    ref_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    req_valid,
  input  wire lemc_op_e                req_op,
  input  wire logic [`LEMC_ADDR_W-1:0] req_addr,
  input  wire logic [`LEMC_DATA_W-1:0] req_data,
  output logic                         req_ready,
  output logic                         rsp_valid,
  output logic [`LEMC_DATA_W-1:0]      rsp_data,
  output logic                         rsp_refused,
  output logic [`LEMC_ADDR_W-1:0]      word_address,
  output logic [`LEMC_DATA_W-1:0]      data_out,
  output logic                         data_oe,
  input  wire logic [`LEMC_DATA_W-1:0] data_in,
  output logic                         device_select_n,
  output logic                         read_drive_n,
  output logic                         chip_clear_high_level,
  output logic                         program_strobe_n
);
  lemc_state_e                 state_reg, state_next;
  lemc_op_e                    op_reg;
  logic [`LEMC_ADDR_W-1:0]     addr_reg;
  logic [`LEMC_DATA_W-1:0]     wdata_reg;
  logic [`LEMC_DATA_W-1:0]     rdata_reg;
  logic                        sel_n_reg;
  logic                        drv_n_reg;
  logic                        hv_reg;
  logic                        strobe_n_reg;
  logic                        oe_reg;
  logic                        ready_reg;
  logic                        rsp_valid_reg;
  logic                        refused_reg;
  logic                        tmr_load;
  logic [`LEMC_CNT_W-1:0]      tmr_count;
  logic                        tmr_done;

  function automatic logic is_program(input lemc_op_e op);
    return (op == LEMC_OP_BYTE_ERASE) || (op == LEMC_OP_BYTE_WRITE)
        || (op == LEMC_OP_CHIP_ERASE);
  endfunction : is_program

  function automatic logic op_next_chip(input lemc_state_e st, input lemc_op_e rq,
                                        input lemc_op_e held);
    return (st == LEMC_ST_IDLE) ? (rq == LEMC_OP_CHIP_ERASE) : (held == LEMC_OP_CHIP_ERASE);
  endfunction : op_next_chip

  // Chip erase needs the high-voltage drive pin, absent on the fast part
  wire req_take    = ready_reg && req_valid;
  wire req_illegal = FAST_DEVICE && (req_op == LEMC_OP_CHIP_ERASE); // R11
  // Erase presents all ones; write presents caller data
  wire [`LEMC_DATA_W-1:0] drive_data = (req_op == LEMC_OP_BYTE_WRITE) ?
                                       req_data : `LEMC_ERASE_DATA; // R2 R5
  wire take_prog   = req_take && !req_illegal && is_program(req_op);
  wire take_read   = req_take && (req_op == LEMC_OP_READ);
  wire take_stby   = req_take && (req_op == LEMC_OP_STANDBY);
  wire take_bad    = req_take && req_illegal;

  // Pins follow the next state so every pin is a plain flop
  wire next_drive  = state_next inside {LEMC_ST_SETUP, LEMC_ST_STROBE};
  wire next_access = (state_next == LEMC_ST_ACCESS);
  wire next_select = next_drive || next_access;
  wire next_strobe = (state_next == LEMC_ST_STROBE);
  wire next_chip   = next_drive && op_next_chip(state_reg, req_op, op_reg);
  wire next_done   = (state_reg != LEMC_ST_DONE) && (state_next == LEMC_ST_DONE);
  wire next_ready  = (state_next == LEMC_ST_IDLE) && !req_take;
  wire read_ends   = (state_reg == LEMC_ST_ACCESS) && tmr_done;

  // Phases never overlap, so each loads the one timer on entry
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_count  = '0;
    unique case (state_reg)
      LEMC_ST_IDLE: begin
        if (take_prog) begin
          state_next = LEMC_ST_SETUP;
          tmr_load   = 1'b1;
          tmr_count  = `LEMC_CNT_W'(`LEMC_SETUP_CYC);
        end else if (take_read) begin
          state_next = LEMC_ST_ACCESS;
          tmr_load   = 1'b1;
          tmr_count  = `LEMC_CNT_W'(`LEMC_ACCESS_CYC); // R14
        end else if (take_stby || take_bad) begin
          state_next = LEMC_ST_DONE;
        end
      end
      LEMC_ST_SETUP: begin
        if (tmr_done) begin
          state_next = LEMC_ST_STROBE;
          tmr_load   = 1'b1;
          tmr_count  = `LEMC_CNT_W'(WRITE_CYC); // R6 R4 R12 R20
        end
      end
      LEMC_ST_STROBE: begin
        if (tmr_done) begin
          state_next = LEMC_ST_RECOVER;
          tmr_load   = 1'b1;
          tmr_count  = `LEMC_CNT_W'(`LEMC_RECOVERY_CYC); // R17
        end
      end
      LEMC_ST_RECOVER: begin
        if (tmr_done) begin
          state_next = LEMC_ST_DONE;
        end
      end
      LEMC_ST_ACCESS: begin
        if (tmr_done) begin
          state_next = LEMC_ST_DONE;
        end
      end
      LEMC_ST_DONE: begin
        state_next = LEMC_ST_IDLE;
      end
      default: begin
        state_next = LEMC_ST_IDLE;
      end
    endcase
  end

  // Shared down counter for setup, strobe, recovery and access
  lemc_timer u_timer (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .count   (tmr_count),
    .expired (tmr_done)
  );

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg <= LEMC_ST_IDLE;
      op_reg    <= LEMC_OP_STANDBY;
      addr_reg  <= '0;
      wdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (req_take) begin
        op_reg    <= req_op;
        addr_reg  <= req_addr; // R15
        wdata_reg <= drive_data;
      end
    end
  end

  // Pin levels; strobe rises only after the full operation time
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sel_n_reg    <= 1'b1; // R10
      drv_n_reg    <= 1'b1;
      hv_reg       <= 1'b0;
      strobe_n_reg <= 1'b1; // R19
      oe_reg       <= 1'b0;
    end else begin
      sel_n_reg    <= !next_select;
      drv_n_reg    <= !next_access; // R9 R18
      hv_reg       <= next_chip; // R11
      strobe_n_reg <= !next_strobe; // R3 R7 R8
      oe_reg       <= next_drive; // R2 R16
    end
  end

  // Caller handshake; erase-before-write ordering is the caller's duty
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ready_reg     <= 1'b0;
      rsp_valid_reg <= 1'b0;
      refused_reg   <= 1'b0;
      rdata_reg     <= '0;
    end else begin
      ready_reg     <= next_ready;
      rsp_valid_reg <= next_done; // R1 R13
      refused_reg   <= (state_reg == LEMC_ST_IDLE) && take_bad;
      if (read_ends) begin
        rdata_reg <= data_in; // R14
      end
    end
  end

  // Drive pin flop is already high whenever the high level is asked
  assign req_ready             = ready_reg;
  assign rsp_valid             = rsp_valid_reg;
  assign rsp_data              = rdata_reg;
  assign rsp_refused           = refused_reg;
  assign word_address          = addr_reg;
  assign data_out              = wdata_reg;
  assign data_oe               = oe_reg;
  assign device_select_n       = sel_n_reg;
  assign read_drive_n          = drv_n_reg;
  assign chip_clear_high_level = hv_reg;
  assign program_strobe_n      = strobe_n_reg;
endmodule : lemc_host

// ===== bench/lemc_host_props.sv
// Pin-level assertions for the latched EEPROM host controller
`include "lemc_defs.svh"
module lemc_host_props
  import lemc_pkg::*;
#(
  parameter int WRITE_CYC   = 100,
  parameter bit FAST_DEVICE = 1'b0
)
(
  input wire logic                    ref_clk,
  input wire logic                    sys_rst,
  input wire logic                    req_ready,
  input wire logic                    rsp_valid,
  input wire logic                    rsp_refused,
  input wire logic [`LEMC_ADDR_W-1:0] word_address,
  input wire logic [`LEMC_DATA_W-1:0] data_out,
  input wire logic                    data_oe,
  input wire logic                    device_select_n,
  input wire logic                    read_drive_n,
  input wire logic                    chip_clear_high_level,
  input wire logic                    program_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] low_cnt_reg;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Counts strobe low cycles; cleared while high
  always_ff @(posedge ref_clk) begin
    if (sys_rst || program_strobe_n) low_cnt_reg <= 24'h000000;
    else low_cnt_reg <= low_cnt_reg + 24'h000001;
  end
  a_strobe_needs_select: assert property (!program_strobe_n |-> !device_select_n)
    else $error("strobe low without select");
  a_strobe_drive_high: assert property (!program_strobe_n |-> read_drive_n && data_oe)
    else $error("strobe low without write levels");
  a_read_no_strobe: assert property (!read_drive_n |-> program_strobe_n && !data_oe)
    else $error("read with strobe or host drive");
  a_standby_floats: assert property (device_select_n |-> !data_oe && program_strobe_n)
    else $error("deselected but driving");
  a_latch_hold: assert property ($fell(program_strobe_n) |=>
    ($stable(word_address) && $stable(data_out))[*8])
    else $error("inputs changed inside hold");
  a_setup_before: assert property ($fell(program_strobe_n) |->
    $past(device_select_n, 13) == 1'b0)
    else $error("select not set up before strobe");
  a_pulse_width: assert property ($rose(program_strobe_n) |-> low_cnt_reg >= WRITE_CYC - 1)
    else $error("strobe pulse too short");
  a_no_hv_fast: assert property (!(FAST_DEVICE && chip_clear_high_level))
    else $error("high level on fast part");
  a_hv_levels: assert property (chip_clear_high_level |-> read_drive_n && !device_select_n)
    else $error("high level outside chip erase");
  a_busy_no_ready: assert property (!program_strobe_n |-> !req_ready)
    else $error("ready while operation runs");
  a_refuse_paired: assert property (rsp_refused |-> rsp_valid)
    else $error("refusal without response");
  c_program: cover property ($fell(program_strobe_n));
  c_read: cover property (!read_drive_n && !device_select_n);
  c_chip: cover property (chip_clear_high_level && !program_strobe_n);
  c_refuse: cover property (rsp_refused);
endmodule : lemc_host_props

bind lemc_host lemc_host_props #(.WRITE_CYC(WRITE_CYC), .FAST_DEVICE(FAST_DEVICE))
  lemc_host_props_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_refused(rsp_refused), .word_address(word_address),
  .data_out(data_out), .data_oe(data_oe), .device_select_n(device_select_n),
  .read_drive_n(read_drive_n), .chip_clear_high_level(chip_clear_high_level),
  .program_strobe_n(program_strobe_n));

// ===== bench/lemc_dev_model.sv
// Behavioural model of the latched 2048 x 8 EEPROM
module lemc_dev_model
#(
  parameter int ACCESS_NS = 180
)
(
  input  wire logic [10:0] word_address,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe,
  output logic [7:0]       data_in,
  input  wire logic        device_select_n,
  input  wire logic        read_drive_n,
  input  wire logic        chip_clear_high_level,
  input  wire logic        program_strobe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:2047];
  wire        rd_on = !device_select_n && !read_drive_n && program_strobe_n;
  // Released lines show the inverse so stale data cannot pass
  assign #(ACCESS_NS) data_in = rd_on ? mem[word_address] : ~mem[word_address];
  initial begin
    for (int i = 0; i < 2048; i++) mem[i] = 8'h00;
  end
  // Completes at once, well inside any allowed duration
  always @(negedge program_strobe_n) begin
    if (!device_select_n && read_drive_n && data_oe) begin
      if (chip_clear_high_level) begin
        for (int i = 0; i < 2048; i++) mem[i] = 8'hFF;
      end else if (data_out == 8'hFF) begin
        mem[word_address] = 8'hFF;
      end else begin
        mem[word_address] = mem[word_address] & data_out;
      end
    end
  end
endmodule : lemc_dev_model

// ===== bench/testbench.sv
// Self-checking bench for the latched EEPROM host controller
module testbench
  import lemc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WCYC  = 100;
  localparam int LIMIT = WCYC + 400;
  logic ref_clk = 1'b0, sys_rst = 1'b1, req_valid = 1'b0;
  lemc_op_e req_op = LEMC_OP_STANDBY;
  logic [10:0] req_addr = 11'h000, word_address;
  logic [7:0]  req_data = 8'h00, rsp_data, data_out, data_in, q;
  logic req_ready, rsp_valid, rsp_refused, data_oe, device_select_n;
  logic read_drive_n, chip_clear_high_level, program_strobe_n;
  logic rq, f_valid = 1'b0, f_ready, f_rsp, f_refused, f_hv, f_sel;
  int   err_count = 0;
  int   tests_run = 0;
  always #2 ref_clk = ~ref_clk;
  lemc_host #(.WRITE_MS(1), .WRITE_CYC(WCYC), .FAST_DEVICE(1'b0)) lemc_host_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_refused(rsp_refused),
    .word_address(word_address), .data_out(data_out), .data_oe(data_oe),
    .data_in(data_in), .device_select_n(device_select_n), .read_drive_n(read_drive_n),
    .chip_clear_high_level(chip_clear_high_level), .program_strobe_n(program_strobe_n));
  lemc_dev_model lemc_dev_model_inst (.word_address(word_address), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .device_select_n(device_select_n),
    .read_drive_n(read_drive_n), .chip_clear_high_level(chip_clear_high_level),
    .program_strobe_n(program_strobe_n));
  lemc_host #(.WRITE_MS(1), .WRITE_CYC(WCYC), .FAST_DEVICE(1'b1)) lemc_host_fast_inst (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .req_valid(f_valid), .req_op(req_op),
    .req_addr(req_addr), .req_data(req_data), .req_ready(f_ready),
    .rsp_valid(f_rsp), .rsp_data(), .rsp_refused(f_refused),
    .word_address(), .data_out(), .data_oe(),
    .data_in(data_in), .device_select_n(f_sel), .read_drive_n(),
    .chip_clear_high_level(f_hv), .program_strobe_n());
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Called at a falling edge; returns there after the response
  task automatic run_op(input lemc_op_e op, input logic [10:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > LIMIT) begin err_count++; close_out(); end
    end
    req_valid = 1'b1;
    req_op    = op;
    req_addr  = a;
    req_data  = d;
    @(negedge ref_clk);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > LIMIT) begin err_count++; close_out(); end
    end
    q = rsp_data;
    rq = rsp_refused;
    @(negedge ref_clk);
  endtask : run_op
  task automatic t_write_read();
    run_op(LEMC_OP_BYTE_ERASE, 11'h001, 8'h00);
    run_op(LEMC_OP_BYTE_WRITE, 11'h001, 8'h3C);
    run_op(LEMC_OP_BYTE_ERASE, 11'h002, 8'h00);
    run_op(LEMC_OP_BYTE_WRITE, 11'h002, 8'hC3);
    run_op(LEMC_OP_READ, 11'h001, 8'h00);
    check("byte 001", q, 8'h3C);
    run_op(LEMC_OP_READ, 11'h002, 8'h00);
    check("byte 002", q, 8'hC3);
    run_op(LEMC_OP_BYTE_ERASE, 11'h7FF, 8'h00);
    run_op(LEMC_OP_READ, 11'h7FF, 8'h00);
    check("erased 7FF", q, 8'hFF);
    $display("test write_read done");
  endtask : t_write_read
  task automatic t_chip_erase();
    run_op(LEMC_OP_CHIP_ERASE, 11'h000, 8'h00);
    check("chip not refused", {7'h00, rq}, 8'h00);
    run_op(LEMC_OP_READ, 11'h001, 8'h00);
    check("chip 001", q, 8'hFF);
    run_op(LEMC_OP_READ, 11'h400, 8'h00);
    check("chip 400", q, 8'hFF);
    $display("test chip_erase done");
  endtask : t_chip_erase
  task automatic t_standby();
    run_op(LEMC_OP_STANDBY, 11'h003, 8'h55);
    check("select idle", {7'h00, device_select_n}, 8'h01);
    check("oe idle", {7'h00, data_oe}, 8'h00);
    run_op(LEMC_OP_READ, 11'h003, 8'h00);
    check("untouched 003", q, 8'hFF);
    $display("test standby done");
  endtask : t_standby
  task automatic t_refuse();
    int n;
    n = 0;
    while (f_ready !== 1'b1) begin
      @(negedge ref_clk);
      if (++n > LIMIT) begin err_count++; close_out(); end
    end
    f_valid = 1'b1;
    req_op  = LEMC_OP_CHIP_ERASE;
    @(negedge ref_clk);
    f_valid = 1'b0;
    check("refused", {7'h00, f_refused}, 8'h01);
    check("refuse rsp", {7'h00, f_rsp}, 8'h01);
    check("fast high level", {7'h00, f_hv}, 8'h00);
    check("fast select", {7'h00, f_sel}, 8'h01);
    @(negedge ref_clk);
    check("refuse pulse", {7'h00, f_refused}, 8'h00);
    $display("test refuse done");
  endtask : t_refuse
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    t_write_read();
    t_chip_erase();
    t_standby();
    t_refuse();
    close_out();
  end
endmodule : testbench
